// ===== hw/rif_framer.sv
// small payload buffer, registered input ready
module rif_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);
    logic [W-1:0] mem [0:D-1];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic push;
    logic pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];

    // occupancy, ready registered from next count
    always_comb begin
        cnt_nxt = cnt_r;
        if (push && !pop) begin
            cnt_nxt = CW'(cnt_r + 1'b1);
        end else if (pop && !push) begin
            cnt_nxt = CW'(cnt_r - 1'b1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            in_ready <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            in_ready <= (cnt_nxt < CW'(D));
        end
    end

    // pointers wrap at depth, not at a power of two
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (push) begin
                wp_r <= (wp_r == AW'(D - 1)) ? '0 : AW'(wp_r + 1'b1);
            end
            if (pop) begin
                rp_r <= (rp_r == AW'(D - 1)) ? '0 : AW'(rp_r + 1'b1);
            end
        end
    end

    // storage needs no reset
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule

// receive indication framer with apb control
module rif_framer #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic hdr_valid,
    input wire rif_pkg::rif_rx_hdr_t hdr,
    output logic hdr_ready,
    input wire logic pay_valid,
    input wire logic [7:0] pay_data,
    output logic pay_ready,
    output logic [7:0] ser_data,
    output logic ser_valid,
    input wire logic ser_ready
);
    logic [31:0] ctrl_r;
    logic [15:0] count_r;
    rif_pkg::rif_state_t state_r;
    rif_pkg::rif_state_t state_nxt;
    logic [rif_pkg::HB_W-1:0] hb_r;
    logic [4:0] idx_r;
    logic [4:0] last_r;
    logic [15:0] left_r;
    logic [7:0] sum_r;
    logic exp_r;
    logic accept;
    logic slot;
    logic emit;
    logic [7:0] emit_byte;
    logic pop;
    logic f_valid;
    logic [7:0] f_data;
    logic [7:0] api_output_options;
    logic use_exp;
    logic setup;
    logic wr;

    assign api_output_options = ctrl_r[7:0];
    // bit1 selects explicit; bit0 routes device-object answers explicitly
    assign use_exp = api_output_options[rif_pkg::AO_EXPLICIT_BIT]
        || (hdr.zdo && api_output_options[rif_pkg::AO_ZDO_BIT]);
    assign accept = hdr_valid && hdr_ready;
    assign slot = !ser_valid || ser_ready;
    assign setup = psel && !penable;
    assign wr = psel && penable && pready && pwrite;

    // build the fixed header, high byte first throughout
    function automatic logic [rif_pkg::HB_W-1:0] build(input rif_pkg::rif_rx_hdr_t h,
                                                       input logic ex);
        logic [rif_pkg::HB_W-1:0] b;
        logic [15:0] len;
        logic [7:0] o;
        b = '0;
        o = 8'h00;
        len = 16'(h.pay_len + 16'(ex ? rif_pkg::HDR_EXP : rif_pkg::HDR_STD)
            - 16'(rif_pkg::OFS_TYPE));
        b[0 +: 8] = rif_pkg::DELIM;
        b[rif_pkg::OFS_LEN*8 +: 16] = {len[7:0], len[15:8]};
        b[rif_pkg::OFS_TYPE*8 +: 8] = ex ? rif_pkg::TYPE_EXP : rif_pkg::TYPE_STD;
        for (int k = 0; k < 8; k++) begin
            b[(rif_pkg::OFS_ADDR64 + k)*8 +: 8] = h.addr64[63 - 8*k -: 8];
        end
        b[rif_pkg::OFS_ADDR16*8 +: 16] = {h.addr16[7:0], h.addr16[15:8]};
        // reserved bits 2 and 3 stay zero; end_dev is ORed with mesh_method[0] into bit 6
        o[rif_pkg::OPT_ACK] = h.opt.acked;
        o[rif_pkg::OPT_BCAST] = h.opt.broadcast;
        o[rif_pkg::OPT_SECURE] = h.opt.secure;
        o[rif_pkg::OPT_APS] = h.opt.aps_enc;
        o[rif_pkg::OPT_DM_MSB:rif_pkg::OPT_DM_LSB] = h.opt.mesh_method;
        o[rif_pkg::OPT_END_DEV] = o[rif_pkg::OPT_END_DEV] | h.opt.end_dev;
        if (ex) begin
            b[rif_pkg::OFS_SRC_EP*8 +: 8] = h.src_ep;
            b[rif_pkg::OFS_DST_EP*8 +: 8] = h.dst_ep;
            b[rif_pkg::OFS_CLUSTER*8 +: 16] = {h.cluster[7:0], h.cluster[15:8]};
            b[rif_pkg::OFS_PROFILE*8 +: 16] = {h.profile[7:0], h.profile[15:8]};
            b[rif_pkg::OFS_OPT_EXP*8 +: 8] = o;
        end else begin
            b[rif_pkg::OFS_OPT_STD*8 +: 8] = o;
        end
        return b;
    endfunction

    // sequencer: header bytes, payload from the buffer, then checksum
    always_comb begin
        state_nxt = state_r;
        emit = 1'b0;
        emit_byte = 8'h00;
        pop = 1'b0;
        case (state_r)
            rif_pkg::ST_IDLE: begin
                if (accept) begin
                    state_nxt = rif_pkg::ST_HDR;
                end
            end
            rif_pkg::ST_HDR: begin
                if (slot) begin
                    emit = 1'b1;
                    emit_byte = hb_r[idx_r*8 +: 8];
                    if (idx_r == last_r) begin
                        state_nxt = (left_r != '0) ? rif_pkg::ST_PAY : rif_pkg::ST_SUM;
                    end
                end
            end
            rif_pkg::ST_PAY: begin
                if (slot && f_valid) begin
                    emit = 1'b1;
                    pop = 1'b1;
                    emit_byte = f_data;
                    if (left_r == 16'h0001) begin
                        state_nxt = rif_pkg::ST_SUM;
                    end
                end
            end
            rif_pkg::ST_SUM: begin
                if (slot) begin
                    emit = 1'b1;
                    emit_byte = 8'(rif_pkg::CSUM_BASE - sum_r);
                    state_nxt = rif_pkg::ST_IDLE;
                end
            end
            default: begin
                state_nxt = rif_pkg::ST_IDLE;
            end
        endcase
    end

    // frame state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= rif_pkg::ST_IDLE;
            hb_r <= '0;
            idx_r <= '0;
            last_r <= '0;
            left_r <= '0;
            exp_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                hb_r <= build(hdr, use_exp);
                idx_r <= '0;
                last_r <= 5'(use_exp ? rif_pkg::HDR_EXP - 1 : rif_pkg::HDR_STD - 1);
                left_r <= hdr.pay_len;
                exp_r <= use_exp;
            end else begin
                if (emit && state_r == rif_pkg::ST_HDR) begin
                    idx_r <= 5'(idx_r + 1'b1);
                end
                if (pop) begin
                    left_r <= 16'(left_r - 1'b1);
                end
            end
        end
    end

    // running sum covers type byte through last payload byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sum_r <= 8'h00;
        end else if (accept) begin
            sum_r <= 8'h00;
        end else if (emit && state_r != rif_pkg::ST_SUM
                     && (state_r == rif_pkg::ST_PAY || idx_r >= 5'(rif_pkg::OFS_TYPE))) begin
            sum_r <= 8'(sum_r + emit_byte);
        end
    end

    // serial output holds its byte until the host takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_valid <= 1'b0;
            ser_data <= 8'h00;
        end else if (emit) begin
            ser_valid <= 1'b1;
            ser_data <= emit_byte;
        end else if (ser_ready) begin
            ser_valid <= 1'b0;
        end
    end

    // new header only when idle and enabled; one frame per packet
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hdr_ready <= 1'b0;
        end else begin
            hdr_ready <= (state_nxt == rif_pkg::ST_IDLE) && !accept
                && ctrl_r[rif_pkg::CTRL_EN_BIT];
        end
    end

    // payload may run ahead of the header, up to the buffer depth
    rif_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(pay_valid),
        .in_data(pay_data),
        .in_ready(pay_ready),
        .out_valid(f_valid),
        .out_ready(pop),
        .out_data(f_data)
    );

    // control register; a write to the counter clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= rif_pkg::CTRL_RST;
        end else if (wr && paddr == rif_pkg::REG_CTRL) begin
            ctrl_r <= pwdata & 32'h000001FF;
        end
    end

    // completed frames; a clear in the same cycle as a count leaves the count at one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_r <= 16'h0000;
        end else if (emit && state_r == rif_pkg::ST_SUM) begin
            count_r <= (wr && paddr == rif_pkg::REG_COUNT) ? 16'h0001 : 16'(count_r + 1'b1);
        end else if (wr && paddr == rif_pkg::REG_COUNT) begin
            count_r <= 16'h0000;
        end
    end

    // apb: zero wait, read data latched in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= 1'b0;
                case (paddr)
                    rif_pkg::REG_CTRL: prdata <= ctrl_r;
                    rif_pkg::REG_STATUS: prdata <= {29'h0, exp_r,
                        state_r == rif_pkg::ST_PAY, state_r != rif_pkg::ST_IDLE};
                    rif_pkg::REG_COUNT: prdata <= {16'h0000, count_r};
                    default: begin
                        prdata <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// ===== hw/rif_pkg.sv
package rif_pkg;
    // frame constants
    localparam logic [7:0] DELIM = 8'h7E;
    localparam logic [7:0] TYPE_STD = 8'h90;
    localparam logic [7:0] TYPE_EXP = 8'h91;
    localparam logic [7:0] CSUM_BASE = 8'hFF;
    // header sizes in bytes, delimiter through the last fixed field
    localparam int HDR_STD = 15;
    localparam int HDR_EXP = 21;
    localparam int HB_W = HDR_EXP * 8;
    // byte offsets
    localparam int OFS_LEN = 1;
    localparam int OFS_TYPE = 3;
    localparam int OFS_ADDR64 = 4;
    localparam int OFS_ADDR16 = 12;
    localparam int OFS_OPT_STD = 14;
    localparam int OFS_SRC_EP = 14;
    localparam int OFS_DST_EP = 15;
    localparam int OFS_CLUSTER = 16;
    localparam int OFS_PROFILE = 18;
    localparam int OFS_OPT_EXP = 20;
    // option byte bit positions
    localparam int OPT_ACK = 0;
    localparam int OPT_BCAST = 1;
    localparam int OPT_SECURE = 4;
    localparam int OPT_APS = 5;
    localparam int OPT_END_DEV = 6;
    localparam int OPT_DM_LSB = 6;
    localparam int OPT_DM_MSB = 7;
    // api_output_options bits
    localparam int AO_ZDO_BIT = 0;
    localparam int AO_EXPLICIT_BIT = 1;
    // apb register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam int CTRL_EN_BIT = 8;
    localparam logic [31:0] CTRL_RST = 32'h00000000;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PAY_BIT = 1;
    localparam int ST_EXP_BIT = 2;

    typedef struct packed {
        logic acked;
        logic broadcast;
        logic secure;
        logic aps_enc;
        logic end_dev;
        logic [1:0] mesh_method;
    } rif_rx_opt_t;

    typedef struct packed {
        logic [63:0] addr64;
        logic [15:0] addr16;
        logic [7:0] src_ep;
        logic [7:0] dst_ep;
        logic [15:0] cluster;
        logic [15:0] profile;
        rif_rx_opt_t opt;
        logic zdo;
        logic [15:0] pay_len;
    } rif_rx_hdr_t;

    typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_PAY, ST_SUM} rif_state_t;
endpackage

// ===== test/rif_framer_checker.sv
module rif_framer_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic hdr_valid,
    input wire logic hdr_ready,
    input wire logic [7:0] ser_data,
    input wire logic ser_valid,
    input wire logic ser_ready
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic mapped;
    // access phase and the three mapped words
    assign acc = psel && penable;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08};
    a_rst_quiet: assert property (disable iff (1'b0)
        !presetn |-> !ser_valid && !hdr_ready && !pready) else $error("output active in reset");
    // a held checksum from the last frame may delay the delimiter, so wait for a free slot
    a_start_delim: assert property (
        hdr_valid && hdr_ready ##1 (!ser_valid || ser_ready) |=> ser_valid && ser_data == 8'h7E)
        else $error("frame did not open with delimiter");
    a_hold_byte: assert property (
        ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
        else $error("byte changed while host stalled");
    // the shortest frame is sixteen bytes, so ready stays low well past eight cycles
    a_busy_no_hdr: assert property (
        hdr_valid && hdr_ready |=> (!hdr_ready) [*8]) else $error("header offered mid frame");
    a_ready_drop: assert property (
        hdr_valid && hdr_ready |=> !hdr_ready) else $error("second header taken");
    a_fell_cause: assert property (
        $fell(hdr_ready) |-> $past(hdr_valid) || $past(psel && pwrite))
        else $error("header ready fell without cause");
    a_pready_on: assert property (acc |-> pready) else $error("wait state inserted");
    a_map_ok: assert property (acc && mapped |-> !pslverr) else $error("error on mapped word");
    a_unmap_err: assert property (acc && !mapped |-> pslverr) else $error("no error on hole");
    c_accept: cover property (hdr_valid && hdr_ready);
    c_stall: cover property (ser_valid && !ser_ready);
    c_unmapped: cover property (acc && pslverr);
endmodule

bind rif_framer rif_framer_checker i_rif_framer_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready),
    .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready), .ser_data(ser_data),
    .ser_valid(ser_valid), .ser_ready(ser_ready));

// ===== test/rif_host_model.sv
module rif_host_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic ser_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // a slow host stalls at random, so held bytes get exercised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ser_ready <= 1'b0;
        end else begin
            ser_ready <= !slow || ($urandom % 3 == 0);
        end
    end
endmodule

// ===== test/rif_framer_tb_top.sv
module rif_framer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, slow;
    logic hdr_valid, hdr_ready, pay_valid, pay_ready, ser_valid, ser_ready;
    logic [7:0] paddr, pay_data, ser_data, nx;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] aos [3] = '{8'h00, 8'h01, 8'h02};
    rif_pkg::rif_rx_hdr_t hdr;
    int failures, checks_done, fc;
    logic [7:0] exp_q[$];
    logic [7:0] seen[$];
`define CHK(nm, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        failures++; \
        $display("Error %s expected %h seen %h", nm, e, s); \
    end \
end

    rif_framer #(.FIFO_DEPTH(4)) i_rif_framer (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr(hdr),
        .hdr_ready(hdr_ready), .pay_valid(pay_valid), .pay_data(pay_data),
        .pay_ready(pay_ready), .ser_data(ser_data), .ser_valid(ser_valid),
        .ser_ready(ser_ready));
    rif_host_model i_rif_host_model (.pclk(pclk), .presetn(presetn), .slow(slow),
        .ser_ready(ser_ready));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // one transfer, then an idle cycle so no signal is driven twice at one edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // answer and read data taken at the rising edge that sees pready
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // notes the whole expected frame, then offers header and payload together
    task automatic send(input logic [7:0] ao, input logic zdo, input int n);
        rif_pkg::rif_rx_hdr_t h;
        logic [143:0] f;
        logic [15:0] len;
        logic [7:0] o, sum;
        logic [7:0] p[$];
        logic ex;
        int k;
        logic [15:0] rl;
        h = 152'({$urandom, $urandom, $urandom, $urandom, $urandom});
        h.opt.mesh_method = 2'(fc);
        h.zdo = zdo;
        h.pay_len = 16'(n);
        ex = ao[1] | (ao[0] & zdo);
        k = ex ? 18 : 12;
        len = 16'(n + k);
        o = {h.opt.mesh_method[1], h.opt.end_dev | h.opt.mesh_method[0], h.opt.aps_enc,
            h.opt.secure, 2'b00, h.opt.broadcast, h.opt.acked};
        f = ex ? {8'h91, h.addr64, h.addr16, h.src_ep, h.dst_ep, h.cluster, h.profile, o}
            : {8'h90, h.addr64, h.addr16, o, 48'h0};
        sum = 8'h00;
        exp_q.push_back(8'h7E);
        exp_q.push_back(len[15:8]);
        exp_q.push_back(len[7:0]);
        for (int i = 0; i < k + n; i++) begin
            p.push_back(i < k ? f[143 - 8 * i -: 8] : 8'($urandom));
            sum += p[i];
            exp_q.push_back(p[i]);
        end
        exp_q.push_back(8'hFF - sum);
        fork
            begin
                hdr <= h;
                hdr_valid <= 1'b1;
                do @(posedge pclk); while (hdr_ready !== 1'b1);
                hdr_valid <= 1'b0;
            end
            begin
                for (int i = k; i < k + n; i++) begin
                    pay_valid <= 1'b1;
                    pay_data <= p[i];
                    do @(posedge pclk); while (pay_ready !== 1'b1);
                end
                pay_valid <= 1'b0;
            end
        join
        for (int t = 0; t < 500 && exp_q.size() > 0; t++) @(posedge pclk);
        @(posedge pclk);
        // host side: whole frame size, then payload length from the length field
        `CHK("frame_len", k + n + 4, seen.size())
        if (seen.size() > 3) begin
            rl = {seen[1], seen[2]} - 16'(seen[3] == 8'h91 ? 18 : 12);
            `CHK("pay_len", 16'(n), rl)
        end
        seen.delete();
        fc++;
    endtask

    // every byte the host takes is matched with the oldest note
    always @(posedge pclk) begin
        if (presetn && ser_valid && ser_ready) begin
            seen.push_back(ser_data);
            nx = exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX;
            `CHK("ser_data", nx, ser_data)
        end
    end

    task automatic final_report;
        $display("Checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // far beyond twelve frames even with a stalling host
    initial begin
        repeat (20000) @(posedge pclk);
        failures++;
        final_report;
    end

    initial begin
        // non-blocking so every process already waits for the falling reset edge
        presetn <= 1'b0;
        {psel, penable, pwrite, hdr_valid, pay_valid, slow} = 6'h00;
        {paddr, pay_data, pwdata} = 48'h0;
        hdr = '0;
        void'($urandom(32'h91DA3050));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // reset values of the three words, then the hole after them
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("rd_rst", 32'h0, rd)
            `CHK("rd_err", i == 3, err)
        end
        apb(1'b1, 8'h00, 32'hFFFFFFFF);
        apb(1'b0, 8'h00, 32'h0);
        `CHK("ctrl_rb", 32'h000001FF, rd)
        // output option table, fast and stalling host, lengths 0 to 10
        for (int i = 0; i < 12; i++) begin
            if (i % 4 == 0) apb(1'b1, 8'h00, {23'h0, 1'b1, aos[i / 4]});
            slow <= i[0];
            send(aos[i / 4], i[1], (i * 3) % 11);
        end
        apb(1'b0, 8'h04, 32'h0);
        `CHK("status", 32'h4, rd)
        apb(1'b0, 8'h08, 32'h0);
        `CHK("count", 32'hC, rd)
        apb(1'b1, 8'h08, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        `CHK("count_clr", 32'h0, rd)
        final_report;
    end
endmodule
